// file: logic/blc_pkg.sv
// Notes on behaviour
// RULE_01: While the hardware enable pin is low the block is off, its registers go to defaults, the bus is ignored and it reports shutdown.
// RULE_02: Once the hardware enable pin is high the block is on and takes register writes from the bus.
// RULE_03: Bits 2:1 of the enable control register switch the two current sinks one by one, and both are on after reset.
// RULE_04: The host programs the strings, sets the chip enable bit, then drives PWM or writes a non-zero code.
// RULE_05: After reset the chip enable bit is 1, the PWM source is chosen and the mapping is linear, so the block waits in standby on PWM.
// RULE_06: A non-zero PWM duty in the default setup becomes a linear 11-bit code that lights the LEDs with no bus writes.
// RULE_07: Standby turns the LEDs off but keeps every register value.
// RULE_08: Chip enable 0 means disabled, no string enabled means standby, and mode 00 with a zero code means standby.
// RULE_09: Mode 00 takes the register code, mode 01 the PWM code, modes 10 and 11 their product, with standby on any zero input.
// RULE_10: The register code is three bits in bits 2:0 of 0x18 and eight bits in bits 7:0 of 0x19.
// RULE_11: Bit 7 of the brightness control register picks exponential mapping when 1 and linear when 0.
// RULE_12: Linear current is 37.806 uA plus 12.195 uA per code step for codes 1 to 2047, and code 0 gives none.
// RULE_13: Exponential current is 50 uA times 1.003040572 to the power of the code for codes 1 to 2047, and code 0 gives none.
// RULE_14: In the product modes the upper 11 bits of the 22-bit product of both codes form the final code.
package blc_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int PWM_SAMPLE_HZ = 4_000_000;
    localparam int PWM_SAMPLE_DIV = CLK_HZ / PWM_SAMPLE_HZ;
    localparam int PWM_WINDOW_LOG2 = 11;
    localparam logic [7:0] OFS_ENABLE = 8'h10;
    localparam logic [7:0] OFS_BRIGHT = 8'h11;
    localparam logic [7:0] OFS_CODE_LO = 8'h18;
    localparam logic [7:0] OFS_CODE_HI = 8'h19;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] RST_ENABLE = 8'h07;
    localparam logic [7:0] RST_BRIGHT = 8'h20;
    localparam logic [7:0] RST_CODE = 8'h00;
    localparam int BIT_CHIP_EN = 0;
    localparam int BIT_STR_LO = 1;
    localparam int BIT_STR_HI = 2;
    localparam int BIT_MODE_LO = 5;
    localparam int BIT_MODE_HI = 6;
    localparam int BIT_EXP = 7;
    localparam logic [6:0] DEV_ADDR = 7'h2a; // arbitrary bus address
    localparam logic [24:0] LIN_BASE_NA = 25'd37806;
    localparam logic [13:0] LIN_STEP_NA = 14'd12195;
    localparam logic [33:0] EXP_BASE_Q8 = 34'd12800000; // 50 uA in nA, 8 fraction bits
    localparam logic [20:0] EXP_RATIO_Q20 = 21'd1051764; // 1.003040572 in Q20
    localparam int EXP_FRAC = 20;

    typedef enum logic [1:0] {ST_DISABLED, ST_STANDBY, ST_ON} blc_op_type;
endpackage : blc_pkg

// file: logic/blc_map_if.sv
`timescale 1ns/100ps
`default_nettype none
interface blc_map_if;
    logic [10:0] code;
    logic exp_sel;
    logic active;
    logic [24:0] current_na;
    logic busy;
    modport ctrl (output code, output exp_sel, output active, input current_na, input busy);
    modport mapper (input code, input exp_sel, input active, output current_na, output busy);
endinterface : blc_map_if
`default_nettype wire

// file: logic/blc_mapper.sv
`timescale 1ns/100ps
`default_nettype none
module blc_mapper
    import blc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    blc_map_if.mapper m
);
    logic [10:0] last_code;
    logic last_exp;
    logic last_active;
    logic [10:0] steps;
    logic [33:0] acc;
    logic running;
    logic [54:0] prod;
    logic [24:0] lin_na;
    logic changed;

    assign prod = acc * EXP_RATIO_Q20;
    assign lin_na = LIN_BASE_NA + 25'(LIN_STEP_NA) * 25'(m.code); // RULE_12
    assign changed = (m.code != last_code) || (m.exp_sel != last_exp) || (m.active != last_active);
    assign m.busy = running;

    // exponent is built by repeated multiply; a full-scale change takes 2047 cycles, ~10 us
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            last_code <= 11'h000;
            last_exp <= 1'b0;
            last_active <= 1'b0;
            steps <= 11'h000;
            acc <= EXP_BASE_Q8;
            running <= 1'b0;
            m.current_na <= 25'h0000000;
        end
        else if (changed)
        begin
            last_code <= m.code;
            last_exp <= m.exp_sel;
            last_active <= m.active;
            steps <= m.code;
            acc <= EXP_BASE_Q8;
            running <= m.exp_sel && m.active && (m.code != 11'h000);
            if (!m.active || m.code == 11'h000)
            begin
                m.current_na <= 25'h0000000; // RULE_12 RULE_13
            end
            else if (!m.exp_sel)
            begin
                m.current_na <= lin_na; // RULE_11 RULE_12
            end
        end
        else if (running)
        begin
            if (steps == 11'h000)
            begin
                running <= 1'b0;
                m.current_na <= acc[32:8]; // RULE_13
            end
            else
            begin
                acc <= prod[EXP_FRAC +: 34]; // RULE_13
                steps <= steps - 11'h001;
            end
        end
    end
endmodule : blc_mapper
`default_nettype wire

// file: logic/blc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module blc_ctrl
    import blc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hardware_enable_pin,
    input wire logic pwm_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [1:0] sink_enable,
    output logic [24:0] led_current_na,
    output logic [10:0] final_code,
    output logic [1:0] op_state,
    output logic shutdown
);
    typedef enum {I_IDLE, I_ADDR, I_ADDR_ACK, I_REG, I_REG_ACK, I_WR, I_WR_ACK, I_RD,
        I_RD_ACK} blc_bus_type;

    logic [3:0] sy1, sy2, sy3, filt, filt_d;
    logic hw_en, pwm_f, scl_f, sda_f;
    logic dev_rst;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    logic [7:0] enable_control, brightness_control, brightness_code_low, brightness_code_high;
    blc_bus_type bus_st;
    logic [2:0] bitcnt;
    logic byte_done;
    logic [7:0] shreg, ptr, rd_byte;
    logic rd_nack;
    logic rd_mode;
    logic wr_strobe;
    logic sample_en;
    logic [7:0] rd_next;
    logic [PWM_WINDOW_LOG2:0] next_high;
    logic [7:0] div_cnt;
    logic [PWM_WINDOW_LOG2-1:0] win_cnt;
    logic [PWM_WINDOW_LOG2:0] high_cnt;
    logic [10:0] pwm_code;
    logic [10:0] reg_code, sel_code;
    logic [21:0] product;
    logic [1:0] mode;
    logic sel_zero;
    blc_op_type next_state;
    blc_map_if map_bus ();

    // pin inputs: a change counts once stages two and three agree
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            // scl and sda idle high, so no false edge follows reset
            sy1 <= 4'h3;
            sy2 <= 4'h3;
            sy3 <= 4'h3;
            filt <= 4'h3;
            filt_d <= 4'h3;
        end
        else
        begin
            sy1 <= {hardware_enable_pin, pwm_in, scl_in, sda_in};
            sy2 <= sy1;
            sy3 <= sy2;
            filt <= (sy2 == sy3) ? sy3 : filt;
            filt_d <= filt;
        end
    end

    assign hw_en = filt[3];
    assign pwm_f = filt[2];
    assign scl_f = filt[1];
    assign sda_f = filt[0];
    assign dev_rst = srst || !hw_en; // RULE_01
    assign scl_rise = scl_f && !filt_d[1];
    assign scl_fall = !scl_f && filt_d[1];
    assign start_ev = scl_f && filt_d[1] && !sda_f && filt_d[0];
    assign stop_ev = scl_f && filt_d[1] && sda_f && !filt_d[0];

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        case (a)
            OFS_ENABLE: read_reg = enable_control;
            OFS_BRIGHT: read_reg = brightness_control;
            OFS_CODE_LO: read_reg = brightness_code_low;
            OFS_CODE_HI: read_reg = brightness_code_high;
            OFS_STATUS: read_reg = {6'h00, op_state};
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    assign rd_next = read_reg(ptr);
    assign wr_strobe = (bus_st == I_WR) && scl_fall && byte_done; // RULE_02

    // bus engine; the pointer advances after each data byte so a host can stream
    always_ff @(posedge sys_clk)
    begin
        if (dev_rst) // RULE_01
        begin
            bus_st <= I_IDLE;
            bitcnt <= 3'h0;
            byte_done <= 1'b0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            rd_byte <= 8'h00;
            rd_nack <= 1'b0;
            rd_mode <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (start_ev)
        begin
            bus_st <= I_ADDR;
            bitcnt <= 3'h0;
            byte_done <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (stop_ev)
        begin
            bus_st <= I_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (bus_st)
                I_ADDR, I_REG, I_WR:
                begin
                    if (scl_rise && !byte_done)
                    begin
                        shreg <= {shreg[6:0], sda_f};
                        bitcnt <= bitcnt + 3'h1;
                        byte_done <= (bitcnt == 3'h7);
                    end
                    else if (scl_fall && byte_done)
                    begin
                        byte_done <= 1'b0;
                        bitcnt <= 3'h0;
                        if (bus_st == I_ADDR)
                        begin
                            if (shreg[7:1] == DEV_ADDR)
                            begin
                                rd_mode <= shreg[0];
                                sda_oe <= 1'b1;
                                bus_st <= I_ADDR_ACK;
                            end
                            else
                            begin
                                bus_st <= I_IDLE;
                            end
                        end
                        else if (bus_st == I_REG)
                        begin
                            ptr <= shreg;
                            sda_oe <= 1'b1;
                            bus_st <= I_REG_ACK;
                        end
                        else
                        begin
                            ptr <= ptr + 8'h01;
                            sda_oe <= 1'b1;
                            bus_st <= I_WR_ACK;
                        end
                    end
                end
                I_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rd_mode)
                        begin
                            rd_byte <= rd_next;
                            sda_oe <= !rd_next[7];
                            bitcnt <= 3'h0;
                            bus_st <= I_RD;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            bus_st <= I_REG;
                        end
                    end
                end
                I_REG_ACK, I_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        bus_st <= I_WR;
                    end
                end
                I_RD:
                begin
                    if (scl_fall)
                    begin
                        if (bitcnt == 3'h7)
                        begin
                            sda_oe <= 1'b0;
                            bitcnt <= 3'h0;
                            bus_st <= I_RD_ACK;
                        end
                        else
                        begin
                            bitcnt <= bitcnt + 3'h1;
                            rd_byte <= {rd_byte[6:0], 1'b0};
                            sda_oe <= !rd_byte[6];
                        end
                    end
                end
                I_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        rd_nack <= sda_f;
                        ptr <= ptr + 8'h01;
                    end
                    else if (scl_fall)
                    begin
                        if (rd_nack)
                        begin
                            bus_st <= I_IDLE;
                        end
                        else
                        begin
                            rd_byte <= rd_next;
                            sda_oe <= !rd_next[7];
                            bus_st <= I_RD;
                        end
                    end
                end
                default:
                begin
                    bus_st <= I_IDLE;
                end
            endcase
        end
    end

    // only srst or the pin clears registers; standby leaves them alone
    always_ff @(posedge sys_clk)
    begin
        if (dev_rst) // RULE_01
        begin
            enable_control <= RST_ENABLE; // RULE_03 RULE_05
            brightness_control <= RST_BRIGHT; // RULE_05
            brightness_code_low <= RST_CODE;
            brightness_code_high <= RST_CODE;
        end
        else if (wr_strobe) // RULE_02 RULE_07
        begin
            case (ptr)
                OFS_ENABLE: enable_control <= shreg;
                OFS_BRIGHT: brightness_control <= shreg;
                OFS_CODE_LO: brightness_code_low <= shreg;
                OFS_CODE_HI: brightness_code_high <= shreg;
                default: ;
            endcase
        end
    end

    // duty is counted over a fixed window of samples; a full window saturates at 2047
    assign sample_en = (div_cnt == 8'(PWM_SAMPLE_DIV - 1));
    assign next_high = high_cnt + {11'h000, pwm_f};

    always_ff @(posedge sys_clk)
    begin
        if (dev_rst)
        begin
            div_cnt <= 8'h00;
            win_cnt <= 11'h000;
            high_cnt <= 12'h000;
            pwm_code <= 11'h000;
        end
        else
        begin
            div_cnt <= sample_en ? 8'h00 : div_cnt + 8'h01;
            if (sample_en)
            begin
                win_cnt <= win_cnt + 11'h001;
                if (win_cnt == 11'h7ff)
                begin
                    pwm_code <= next_high[PWM_WINDOW_LOG2] ? 11'h7ff : next_high[10:0]; // RULE_06
                    high_cnt <= 12'h000;
                end
                else
                begin
                    high_cnt <= next_high;
                end
            end
        end
    end

    assign reg_code = {brightness_code_high, brightness_code_low[2:0]}; // RULE_10
    assign mode = brightness_control[BIT_MODE_HI:BIT_MODE_LO];
    assign product = 22'(reg_code) * 22'(pwm_code); // RULE_14

    always_comb
    begin
        case (mode)
            2'b00: sel_code = reg_code; // RULE_09
            2'b01: sel_code = pwm_code; // RULE_09
            default: sel_code = product[21:11]; // RULE_09 RULE_14
        endcase
    end

    // a product whose upper bits are zero is dark, so it counts as standby too
    assign sel_zero = (sel_code == 11'h000);

    always_comb
    begin
        next_state = ST_ON;
        if (!enable_control[BIT_CHIP_EN])
            next_state = ST_DISABLED; // RULE_08
        else if (enable_control[BIT_STR_HI:BIT_STR_LO] == 2'b00)
            next_state = ST_STANDBY; // RULE_08
        else if (sel_zero)
            next_state = ST_STANDBY; // RULE_08 RULE_09
    end

    always_ff @(posedge sys_clk)
    begin
        if (dev_rst) // RULE_01
        begin
            op_state <= ST_DISABLED;
            final_code <= 11'h000;
            sink_enable <= RST_ENABLE[BIT_STR_HI:BIT_STR_LO];
            shutdown <= 1'b1;
        end
        else
        begin
            op_state <= next_state;
            final_code <= (next_state == ST_ON) ? sel_code : 11'h000; // RULE_06 RULE_09
            sink_enable <= enable_control[BIT_STR_HI:BIT_STR_LO]; // RULE_03
            shutdown <= (next_state != ST_ON); // RULE_07
        end
    end

    assign map_bus.code = final_code;
    assign map_bus.exp_sel = brightness_control[BIT_EXP]; // RULE_11
    assign map_bus.active = (op_state == ST_ON);

    blc_mapper u_map (
        .sys_clk(sys_clk),
        .rst(dev_rst),
        .m(map_bus.mapper)
    );

    // old current holds while an exponential value is rebuilt, trading latency for no glitch
    always_ff @(posedge sys_clk)
    begin
        if (dev_rst) // RULE_01
            led_current_na <= 25'h0000000;
        else if (!map_bus.busy)
            led_current_na <= map_bus.current_na; // RULE_12 RULE_13
    end
endmodule : blc_ctrl
`default_nettype wire

// file: tb/blc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module blc_chk
    import blc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hardware_enable_pin,
    input wire logic sda_oe,
    input wire logic [1:0] sink_enable,
    input wire logic [24:0] led_current_na,
    input wire logic [10:0] final_code,
    input wire logic [1:0] op_state,
    input wire logic shutdown
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_low; !hardware_enable_pin [*8]; endsequence
    sequence s_dark; (op_state != ST_ON) [*4]; endsequence
    sequence s_rise; $rose(hardware_enable_pin); endsequence
    property p_shut; !hardware_enable_pin |-> ##[0:6] shutdown; endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_dis; s_low |-> op_state == ST_DISABLED; endproperty
    a_dis: assert property (p_dis) else $error("not disabled");
    property p_quiet; s_low |-> !sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("bus driven");
    property p_sink; s_rise |-> ##[1:4] sink_enable == 2'b11; endproperty
    a_sink: assert property (p_sink) else $error("sinks off");
    property p_wake; s_rise |-> ##[1:8] op_state == ST_STANDBY; endproperty
    a_wake: assert property (p_wake) else $error("no standby");
    property p_dark; s_dark |-> led_current_na == 25'h0; endproperty
    a_dark: assert property (p_dark) else $error("lit off");
    property p_zero; (final_code == 11'h0) [*8] |-> ##[0:40] led_current_na == 25'h0; endproperty
    a_zero: assert property (p_zero) else $error("code 0 lit");
    property p_on; (op_state == ST_ON) [*2] |-> final_code != 11'h0; endproperty
    a_on: assert property (p_on) else $error("on at 0");
endmodule : blc_chk
bind blc_ctrl blc_chk u_chk (
    .sys_clk(sys_clk),
    .srst(srst),
    .hardware_enable_pin(hardware_enable_pin),
    .sda_oe(sda_oe),
    .sink_enable(sink_enable),
    .led_current_na(led_current_na),
    .final_code(final_code),
    .op_state(op_state),
    .shutdown(shutdown)
);
`default_nettype wire

// file: tb/blc_host.sv
`timescale 1ns/100ps
`default_nettype none
module blc_host
    import blc_pkg::*;
(
    input wire logic sys_clk,
    output logic scl,
    output logic sda,
    output logic pwm
);
    initial {scl, sda, pwm} = 3'b110;
    // a third of the shortest legal scl period, so bits never run fast
    task automatic q(input logic c, input logic d);
        repeat (167) @(negedge sys_clk);
        {scl, sda} = {c, d};
    endtask : q
    // acks are released high and left to the pull-up
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        logic [26:0] f;
        f = {DEV_ADDR, 2'b01, r, 1'b1, d, 1'b1};
        q(1'b1, 1'b0);
        q(1'b0, 1'b0);
        for (int i = 26; i >= 0; i--)
        begin
            q(1'b0, f[i]);
            q(1'b1, f[i]);
            q(1'b0, f[i]);
        end
        q(1'b0, 1'b0);
        q(1'b1, 1'b0);
        q(1'b1, 1'b1);
    endtask : wr
endmodule : blc_host
`default_nettype wire

// file: tb/tb_backlight_enable_brightness_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_backlight_enable_brightness_ctrl
    import blc_pkg::*;
;
    typedef struct packed {logic [7:0] r; logic [7:0] d; blc_op_type s; logic [10:0] c;} blc_row_type;
    blc_row_type rows [5] = '{'{8'h19, 8'hff, ST_STANDBY, 11'h0}, '{8'h11, 8'h00, ST_ON, 11'h7f8},
        '{8'h10, 8'h01, ST_STANDBY, 11'h0}, '{8'h10, 8'h03, ST_ON, 11'h7f8},
        '{8'h11, 8'h80, ST_ON, 11'h7f8}};
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic hardware_enable_pin = 1'b0;
    logic scl_in, sda_h, pwm_in, sda_out, sda_oe, shutdown;
    logic [1:0] sink_enable, op_state;
    logic [24:0] led_current_na;
    logic [10:0] final_code;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    real e;
    // open drain with pull-up
    wire logic sda_in = sda_h & ~(sda_oe & ~sda_out);
    always #2.5 sys_clk = ~sys_clk;
    blc_host h (.sys_clk(sys_clk), .scl(scl_in), .sda(sda_h), .pwm(pwm_in));
    blc_ctrl uut (
        .sys_clk(sys_clk),
        .srst(srst),
        .hardware_enable_pin(hardware_enable_pin),
        .pwm_in(pwm_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .sink_enable(sink_enable),
        .led_current_na(led_current_na),
        .final_code(final_code),
        .op_state(op_state),
        .shutdown(shutdown)
    );
    function automatic logic [24:0] lin(input logic [10:0] c);
        return (c == 11'h0) ? 25'h0 : LIN_BASE_NA + LIN_STEP_NA * c;
    endfunction : lin
    task automatic chk(input string n, input logic [24:0] x, input logic [24:0] g);
        check_count++;
        if (g !== x)
        begin
            errors++;
            $display("unexpected %s expected %0d seen %0d", n, x, g);
        end
    endtask : chk
    task automatic conclude();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        repeat (8) @(negedge sys_clk);
        chk("shutdown", 25'h1, 25'(shutdown));
        srst = 1'b0;
        hardware_enable_pin = 1'b1;
        repeat (20) @(negedge sys_clk);
        foreach (rows[i])
        begin
            h.wr(rows[i].r, rows[i].d);
            repeat (300) @(negedge sys_clk);
            chk("state", 25'(rows[i].s), 25'(op_state));
            if (rows[i].c != 11'h0)
                chk("code", 25'(rows[i].c), 25'(final_code));
            if (i < 4)
                chk("current", lin(rows[i].c), led_current_na);
        end
        // the exponential value takes one cycle per code step to rebuild
        repeat (2100) @(negedge sys_clk);
        e = 50000.0 * (1.003040572 ** 2040);
        chk("exp", 25'h1, 25'(led_current_na > e * 0.98 && led_current_na < e * 1.02));
        hardware_enable_pin = 1'b0;
        repeat (20) @(negedge sys_clk);
        chk("off", 25'h0, led_current_na);
        hardware_enable_pin = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk("wake", 25'(ST_STANDBY), 25'(op_state));
        chk("sinks", 25'h3, 25'(sink_enable));
        conclude();
    end
endmodule : tb_backlight_enable_brightness_ctrl
`default_nettype wire
